// ### hdl/serial_alarm_pkg.sv
// Shared constants and types of the serial input and alarm block
package serial_alarm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int START_PULSE_NS = 80;
  localparam int CONV_NS = 4000;
  localparam int SCLK_HALF_NS = 200;
  localparam int START_PULSE_CYC =
    (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;
  localparam int WORD_BITS = 16;
  localparam int BITS_W = 5;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_TEMP_LOW_THR = 10'h208;
  localparam logic [9:0] ADDR_TEMP_HIGH_THR = 10'h209;
  localparam logic [9:0] ADDR_DATA_LOW_THR = 10'h20A;
  localparam logic [9:0] ADDR_DATA_HIGH_THR = 10'h20B;
  localparam logic [9:0] ADDR_RESULT_LOW = 10'h20E;
  localparam logic [9:0] ADDR_RESULT_HIGH = 10'h20F;
  localparam logic [9:0] ADDR_TEMP_ALARM_EN = 10'h210;
  localparam logic [9:0] ADDR_DATA_ALARM_EN = 10'h211;
  localparam logic [9:0] ADDR_LOG_CFG = 10'h213;
  localparam logic [9:0] ADDR_ALARM_STATUS = 10'h214;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int EN_LOW_BIT = 0;
  localparam int EN_HIGH_BIT = 1;
  localparam int LOG_EDL_BIT = 1;
  localparam int LOG_FMT_BIT = 3;
  localparam logic [5:0] TEMP_EN_PAD = 6'h00;
  localparam logic [5:0] DATA_EN_PAD = 6'h3F;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [1:0] EN_RST = 2'h0;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  typedef enum logic [1:0] {
    ACQ_IDLE = 2'h0, ACQ_START = 2'h1, ACQ_CONV = 2'h3, ACQ_SHIFT = 2'h2
  } acq_state_type;
endpackage

// ### hdl/acq_link_if.sv
// Link between the register side and the serial shifter
interface acq_link_if;
  logic start;
  logic busy;
  logic done;
  logic [serial_alarm_pkg::WORD_BITS-1:0] word;
  modport ctrl (output start, input busy, input done, input word);
  modport shifter (input start, output busy, output done, output word);
endinterface

// ### hdl/alarm_compare.sv
// Threshold comparator for one alarm channel
module alarm_compare (
  input wire logic [7:0] value,
  input wire logic [7:0] low_thr,
  input wire logic [7:0] high_thr,
  input wire logic [1:0] en,
  output logic hit_low,
  output logic hit_high
);
  // Unsigned compare, equality counts as a hit
  assign hit_low = en[serial_alarm_pkg::EN_LOW_BIT] && (value <= low_thr);
  assign hit_high = en[serial_alarm_pkg::EN_HIGH_BIT] &&
                    (value >= high_thr);
endmodule // alarm_compare

// ### hdl/serial_shifter.sv
// Conversion start, serial clock and 16-bit shift-in
module serial_shifter (
  input wire logic core_clk,
  input wire logic rstn,
  acq_link_if.shifter link,
  input wire logic acq_serial_in,
  output logic conversion_start_out,
  output logic sclk_out,
  output logic pump_enable_n
);
  localparam int DONE_CYC = serial_alarm_pkg::START_PULSE_CYC +
    serial_alarm_pkg::CONV_CYC +
    2 * serial_alarm_pkg::WORD_BITS * serial_alarm_pkg::HALF_CYC;
  localparam int TW = serial_alarm_pkg::TIMER_W;
  localparam int BW = serial_alarm_pkg::BITS_W;
  typedef struct packed {
    serial_alarm_pkg::acq_state_type st;
    logic [TW-1:0] timer;
    logic [BW-1:0] bits;
    logic [15:0] word;
    logic cnv;
    logic sclk;
    logic pump_n;
    logic busy;
    logic done;
  } shift_state_type;
  shift_state_type s_r, s_nxt;
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // All edges are counted on core_clk, the on-chip oscillator
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      serial_alarm_pkg::ACQ_IDLE: begin
        if (link.start) begin
          s_nxt.st = serial_alarm_pkg::ACQ_START;
          s_nxt.cnv = 1'b1;
          s_nxt.pump_n = 1'b0;
          s_nxt.busy = 1'b1;
          s_nxt.timer = TW'(serial_alarm_pkg::START_PULSE_CYC - 1);
          s_nxt.bits = '0;
          s_nxt.word = serial_alarm_pkg::RESULT_RST;
        end
      end
      serial_alarm_pkg::ACQ_START: begin
        if (s_r.timer == '0) begin
          s_nxt.st = serial_alarm_pkg::ACQ_CONV;
          s_nxt.cnv = 1'b0;
          s_nxt.timer = TW'(serial_alarm_pkg::CONV_CYC - 1);
        end else begin
          s_nxt.timer = s_r.timer - 1'b1;
        end
      end
      serial_alarm_pkg::ACQ_CONV: begin
        // No busy line from the converter, so wait its worst case
        if (s_r.timer == '0) begin
          s_nxt.st = serial_alarm_pkg::ACQ_SHIFT;
          s_nxt.timer = TW'(serial_alarm_pkg::HALF_CYC - 1);
        end else begin
          s_nxt.timer = s_r.timer - 1'b1;
        end
      end
      serial_alarm_pkg::ACQ_SHIFT: begin
        if (s_r.timer != '0) begin
          s_nxt.timer = s_r.timer - 1'b1;
        end else if (!s_r.sclk) begin
          s_nxt.timer = TW'(serial_alarm_pkg::HALF_CYC - 1);
          s_nxt.sclk = 1'b1;
          // Sampled at the rising edge, first bit ends in bit 15
          // Pin pulldown fills missing trailing bits with zero
          s_nxt.word = {s_r.word[14:0], acq_serial_in};
          s_nxt.bits = s_r.bits + 1'b1;
        end else begin
          s_nxt.timer = TW'(serial_alarm_pkg::HALF_CYC - 1);
          s_nxt.sclk = 1'b0;
          if (s_r.bits == BW'(serial_alarm_pkg::WORD_BITS)) begin
            s_nxt.st = serial_alarm_pkg::ACQ_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.pump_n = 1'b1;
            s_nxt.done = 1'b1;
          end
        end
      end
      default: s_nxt.st = serial_alarm_pkg::ACQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: serial_alarm_pkg::ACQ_IDLE, pump_n: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign conversion_start_out = s_r.cnv;
  assign sclk_out = s_r.sclk;
  assign pump_enable_n = s_r.pump_n;
  assign link.busy = s_r.busy;
  assign link.done = s_r.done;
  assign link.word = s_r.word;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [BW-1:0] rise_cnt;
  logic first_bit;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rise_cnt <= '0;
      first_bit <= 1'b0;
    end else if (link.start && !s_r.busy) begin
      rise_cnt <= '0;
    end else if (s_nxt.sclk && !s_r.sclk) begin
      rise_cnt <= rise_cnt + 1'b1;
      if (rise_cnt == '0) begin
        first_bit <= acq_serial_in;
      end
    end
  end
  sixteen_rises_a: assert property (@(posedge core_clk) disable iff (!rstn)
    link.done |-> rise_cnt == 5'h10) else $error("rise count not 16");
  first_bit_top_a: assert property (@(posedge core_clk) disable iff (!rstn)
    link.done |-> link.word[15] == first_bit) else $error("bit 15 wrong");
  start_width_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(conversion_start_out) |=> conversion_start_out ##1
    !conversion_start_out) else $error("start pulse width wrong");
  sclk_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(conversion_start_out) |-> !sclk_out [*8])
    else $error("sclk during conversion");
  done_time_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(link.busy) |-> ##DONE_CYC link.done) else $error("done late");
  pump_on_a: assert property (@(posedge core_clk) disable iff (!rstn)
    link.busy |-> !pump_enable_n) else $error("pump off while busy");
  acq_done_c: cover property (@(posedge core_clk) disable iff (!rstn)
    link.done);
endmodule // serial_shifter

// ### hdl/serial_input_alarm_logic.sv
// Serial converter readout, result registers, logging and alarms
// Notes on behaviour
// - Every acquisition shifts in exactly sixteen bits
// - First received bit lands in bit 15, later bits below it
// - Latest word reads as low byte then high byte at next address
// - Acquire on forced conversion, or in mission with data logging on
// - Pulse conversion start, then clock data in on rising edges
// - All link timing counts on the internal oscillator clock
// - Missing trailing bits from a short converter read as zero
// - In mission log high byte of tick acquisitions (not forced), low byte only in 16-bit mode
// - Data alarms compare the unsigned high byte only
// - Data low threshold then data high threshold, consecutive
// - Temperature alarm needs hit and enable; thresholds consecutive
// - Enabled: temperature at or below low threshold sets low flag
// - Enabled: temperature at or above high threshold sets high flag
// - Enabled: data at or below low threshold sets data low flag
// - Enabled: data at or above high threshold sets data high flag
// - All four alarm flags live in the alarm status register
// - Temp enable upper bits read 0; register locked during mission
// - Data enable upper bits read 1; register locked during mission
// - Provide a charge pump enable for the acquisition
// - Temperature alarms use the high byte of the conversion only
// - Format bit 3 selects 8-bit (0) or 16-bit (1) logging
//
// The address-and-strobe port was decided locally.
module serial_input_alarm_logic (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic mission_active,
  input wire logic forced_conv,
  input wire logic sample_tick,
  input wire logic temp_valid,
  input wire logic [15:0] temp_result,
  input wire logic alarm_clear,
  input wire logic acq_serial_in,
  output logic conversion_start_out,
  output logic sclk_out,
  output logic pump_enable_n,
  output logic log_valid,
  output logic [7:0] log_byte,
  output logic [3:0] alarm_flags
);
  typedef struct packed {
    logic [3:0][7:0] thr;
    logic [15:0] result;
    logic [1:0] temp_en;
    logic [1:0] data_en;
    logic edl;
    logic fmt16;
    logic [3:0] flags;
    logic [7:0] rdata;
    logic log_valid;
    logic [7:0] log_data;
    logic low_pend;
    logic mission_acq;
    logic start;
  } main_state_type;
  main_state_type s_r, s_nxt;

  acq_link_if link ();
  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  // The shifter keeps its own side of the link timing
  serial_shifter u_shifter (
    .core_clk(core_clk),
    .rstn(rstn),
    .link(link),
    .acq_serial_in(acq_serial_in),
    .conversion_start_out(conversion_start_out),
    .sclk_out(sclk_out),
    .pump_enable_n(pump_enable_n)
  );
  assign link.start = s_r.start;
  // ----------------------------------------------------------------
  // Alarm compare, channel 0 temperature, channel 1 serial data
  // ----------------------------------------------------------------
  logic [1:0][7:0] cmp_val;
  logic [1:0][1:0] cmp_en;
  logic [1:0] cmp_event;
  logic [1:0] hit_low;
  logic [1:0] hit_high;
  logic [3:0] alarm_set;
  assign cmp_val[0] = temp_result[15:8];
  assign cmp_val[1] = link.word[15:8];
  assign cmp_en[0] = s_r.temp_en;
  assign cmp_en[1] = s_r.data_en;
  assign cmp_event[0] = temp_valid && mission_active;
  assign cmp_event[1] = link.done && mission_active;
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_alarm
      alarm_compare u_cmp (
        .value(cmp_val[c]),
        .low_thr(s_r.thr[2*c]),
        .high_thr(s_r.thr[2*c+1]),
        .en(cmp_en[c]),
        .hit_low(hit_low[c]),
        .hit_high(hit_high[c])
      );
      // Hit and enable both needed
      assign alarm_set[2*c] = cmp_event[c] && hit_low[c];
      assign alarm_set[2*c+1] = cmp_event[c] && hit_high[c];
    end
  endgenerate
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic acq_req;
  assign acq_req = forced_conv ||
                   (sample_tick && mission_active && s_r.edl);

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.log_valid = 1'b0;
    s_nxt.rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        serial_alarm_pkg::ADDR_TEMP_LOW_THR: s_nxt.thr[0] = reg_wdata;
        serial_alarm_pkg::ADDR_TEMP_HIGH_THR: s_nxt.thr[1] = reg_wdata;
        serial_alarm_pkg::ADDR_DATA_LOW_THR: s_nxt.thr[2] = reg_wdata;
        serial_alarm_pkg::ADDR_DATA_HIGH_THR: s_nxt.thr[3] = reg_wdata;
        serial_alarm_pkg::ADDR_TEMP_ALARM_EN: begin
          if (!mission_active) begin
            s_nxt.temp_en = {reg_wdata[serial_alarm_pkg::EN_HIGH_BIT],
                             reg_wdata[serial_alarm_pkg::EN_LOW_BIT]};
          end
        end
        serial_alarm_pkg::ADDR_DATA_ALARM_EN: begin
          if (!mission_active) begin
            s_nxt.data_en = {reg_wdata[serial_alarm_pkg::EN_HIGH_BIT],
                             reg_wdata[serial_alarm_pkg::EN_LOW_BIT]};
          end
        end
        serial_alarm_pkg::ADDR_LOG_CFG: begin
          if (!mission_active) begin
            s_nxt.edl = reg_wdata[serial_alarm_pkg::LOG_EDL_BIT];
            s_nxt.fmt16 = reg_wdata[serial_alarm_pkg::LOG_FMT_BIT];
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        serial_alarm_pkg::ADDR_TEMP_LOW_THR: s_nxt.rdata = s_r.thr[0];
        serial_alarm_pkg::ADDR_TEMP_HIGH_THR: s_nxt.rdata = s_r.thr[1];
        serial_alarm_pkg::ADDR_DATA_LOW_THR: s_nxt.rdata = s_r.thr[2];
        serial_alarm_pkg::ADDR_DATA_HIGH_THR: s_nxt.rdata = s_r.thr[3];
        serial_alarm_pkg::ADDR_RESULT_LOW: s_nxt.rdata = s_r.result[7:0];
        serial_alarm_pkg::ADDR_RESULT_HIGH: s_nxt.rdata = s_r.result[15:8];
        serial_alarm_pkg::ADDR_TEMP_ALARM_EN:
          s_nxt.rdata = {serial_alarm_pkg::TEMP_EN_PAD, s_r.temp_en};
        serial_alarm_pkg::ADDR_DATA_ALARM_EN:
          s_nxt.rdata = {serial_alarm_pkg::DATA_EN_PAD, s_r.data_en};
        serial_alarm_pkg::ADDR_LOG_CFG:
          s_nxt.rdata = {4'h0, s_r.fmt16, 1'b0, s_r.edl, 1'b0};
        serial_alarm_pkg::ADDR_ALARM_STATUS:
          s_nxt.rdata = {4'h0, s_r.flags};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // A request while the link is busy is dropped, not queued
    if (acq_req && !link.busy && !s_r.start) begin
      s_nxt.start = 1'b1;
      s_nxt.mission_acq = !forced_conv && mission_active && s_r.edl;
    end
    if (link.done) begin
      s_nxt.result = link.word;
      if (s_r.mission_acq) begin
        s_nxt.log_valid = 1'b1;
        s_nxt.log_data = link.word[15:8];
        s_nxt.low_pend = s_r.fmt16;
      end
    end else if (s_r.low_pend) begin
      // Low byte follows, high byte first keeps it at the lower address
      s_nxt.log_valid = 1'b1;
      s_nxt.log_data = s_r.result[7:0];
      s_nxt.low_pend = 1'b0;
    end
    // A new hit in the clearing cycle wins over the clear
    s_nxt.flags = (s_r.flags & ~{4{alarm_clear}}) | alarm_set;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{thr: {4{serial_alarm_pkg::THR_RST}},
               result: serial_alarm_pkg::RESULT_RST,
               temp_en: serial_alarm_pkg::EN_RST,
               data_en: serial_alarm_pkg::EN_RST,
               flags: serial_alarm_pkg::FLAGS_RST,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign log_valid = s_r.log_valid;
  assign log_byte = s_r.log_data;
  assign alarm_flags = s_r.flags;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] res_hi;
  logic [7:0] word_hi;
  assign res_hi = s_r.result[15:8];
  assign word_hi = link.word[15:8];

  result_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    reg_rd && reg_addr == serial_alarm_pkg::ADDR_RESULT_HIGH |=>
    reg_rdata == $past(res_hi)) else $error("result high read wrong");
  start_cause_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(link.busy) |-> $past(link.start) && $past(acq_req, 2))
    else $error("acquisition without cause");
  log_bytes_a: assert property (@(posedge core_clk) disable iff (!rstn)
    link.done && s_r.mission_acq |=> log_valid && log_byte ==
    $past(word_hi) ##1 log_valid == s_r.fmt16) else $error("log order");
  data_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
    link.done && mission_active && s_r.data_en[1] &&
    link.word[15:8] >= s_r.thr[3] |=> alarm_flags[3])
    else $error("data high flag missing");
  data_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
    link.done && mission_active && !s_r.data_en[0] && !alarm_flags[2] |=>
    !alarm_flags[2]) else $error("data low flag while disabled");
  temp_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
    temp_valid && mission_active && s_r.temp_en[0] &&
    temp_result[15:8] <= s_r.thr[0] |=> alarm_flags[0])
    else $error("temp low flag missing");
  temp_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
    temp_valid && mission_active && s_r.temp_en[1] &&
    temp_result[15:8] >= s_r.thr[1] |=> alarm_flags[1])
    else $error("temp high flag missing");
  en_locked_a: assert property (@(posedge core_clk) disable iff (!rstn)
    mission_active && reg_wr &&
    reg_addr == serial_alarm_pkg::ADDR_TEMP_ALARM_EN |=> $stable(s_r.temp_en))
    else $error("temp enable written in mission");
  data_pad_a: assert property (@(posedge core_clk) disable iff (!rstn)
    reg_rd && reg_addr == serial_alarm_pkg::ADDR_DATA_ALARM_EN |=>
    reg_rdata[7:2] == 6'h3F) else $error("data enable pad not ones");
  flag_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !alarm_clear |=> (alarm_flags & $past(alarm_flags)) == $past(alarm_flags))
    else $error("alarm flag lost");
  mission_log_c: cover property (@(posedge core_clk) disable iff (!rstn)
    log_valid ##1 log_valid);
  data_alarm_c: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(alarm_flags[3]));
  temp_alarm_c: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(alarm_flags[0]));
endmodule // serial_input_alarm_logic

// ### test/adc_model.sv
// Behavioural serial converter driving the acquisition input
module adc_model (
  input wire logic core_clk,
  input wire logic conversion_start_out,
  input wire logic sclk_out,
  input wire logic [15:0] word,
  input wire logic [4:0] nbits,
  output logic acq_serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  int idx;
  initial begin
    acq_serial_in = 1'b0;
    sclk_q = 1'b0;
    idx = 16;
  end
  // ----------------------------------------------------------------
  // Shift out on falling serial clock, far from the rising sample
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    sclk_q <= sclk_out;
    if (conversion_start_out) idx = 0;
    else if (sclk_q && !sclk_out) idx = idx + 1;
    // MSB first; beyond nbits the line falls to its pulldown
    acq_serial_in <= (idx < nbits) ? word[15 - idx] : 1'b0;
  end
endmodule // adc_model

// ### test/serial_input_alarm_logic_tb.sv
// Register-level testbench of the serial input and alarm block
module serial_input_alarm_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, log_byte;
  logic mission_active = 1'b0, forced_conv = 1'b0, sample_tick = 1'b0;
  logic temp_valid = 1'b0, alarm_clear = 1'b0, acq_serial_in;
  logic [15:0] temp_result = 16'h0000, word = 16'h0000;
  logic [4:0] nbits = 5'h10;
  logic conversion_start_out, sclk_out, pump_enable_n, log_valid, sclk_q;
  logic [3:0] alarm_flags;
  logic [7:0] logq[$];
  int n_fail = 0, samples_checked = 0, rises = 0, cnv = 0;
  always #20 core_clk = ~core_clk;
  serial_input_alarm_logic u_dut (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mission_active(mission_active), .forced_conv(forced_conv),
    .sample_tick(sample_tick), .temp_valid(temp_valid),
    .temp_result(temp_result), .alarm_clear(alarm_clear),
    .acq_serial_in(acq_serial_in),
    .conversion_start_out(conversion_start_out), .sclk_out(sclk_out),
    .pump_enable_n(pump_enable_n), .log_valid(log_valid),
    .log_byte(log_byte), .alarm_flags(alarm_flags));
  adc_model u_adc (.core_clk(core_clk),
    .conversion_start_out(conversion_start_out), .sclk_out(sclk_out),
    .word(word), .nbits(nbits), .acq_serial_in(acq_serial_in));
  // ----------------------------------------------------------------
  // Monitors and shared tasks
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    sclk_q <= sclk_out;
    if (sclk_out === 1'b1 && sclk_q === 1'b0) rises <= rises + 1;
    if (conversion_start_out === 1'b1) cnv <= cnv + 1;
    if (log_valid === 1'b1) logq.push_back(log_byte);
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic msn(input logic v);
    @(posedge core_clk);
    mission_active <= v;
  endtask
  task automatic wait_pump(input logic lvl);
    int i;
    for (i = 0; i < 400 && pump_enable_n !== lvl; i++) @(posedge core_clk);
    if (i == 400) begin
      n_fail++;
      $display("ERROR %0t acquisition hung", $time);
      wrap_up();
    end
  endtask
  // One acquisition; tick selects the mission path over forced
  task automatic acq(input logic [15:0] w, input logic [4:0] n,
                     input logic tick);
    @(posedge core_clk);
    word <= w;
    nbits <= n;
    rises <= 0;
    cnv <= 0;
    logq.delete();
    if (tick) sample_tick <= 1'b1;
    else forced_conv <= 1'b1;
    @(posedge core_clk);
    sample_tick <= 1'b0;
    forced_conv <= 1'b0;
    wait_pump(1'b0);
    wait_pump(1'b1);
    repeat (4) @(posedge core_clk);
    #1 check(16'(rises), 16'd16);
    check(16'(cnv), 16'd2);
  endtask
  task automatic tmp(input logic [7:0] hb, input logic [3:0] e);
    @(posedge core_clk);
    temp_valid <= 1'b1;
    temp_result <= {hb, 8'hFF};
    @(posedge core_clk);
    temp_valid <= 1'b0;
    @(posedge core_clk);
    #1 check({12'h000, alarm_flags}, {12'h000, e});
  endtask
  task automatic clr();
    @(posedge core_clk);
    alarm_clear <= 1'b1;
    @(posedge core_clk);
    alarm_clear <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 4; k++) rd(10'h208 + 10'(k), 8'h00);
    rd(10'h20E, 8'h00);
    rd(10'h210, 8'h00);
    rd(10'h211, 8'hFC);
    rd(10'h3FF, 8'h00);
    $display("test reset done");
    wr(10'h208, 8'h30);
    wr(10'h209, 8'h80);
    wr(10'h20A, 8'h10);
    wr(10'h20B, 8'h40);
    rd(10'h20A, 8'h10);
    rd(10'h20B, 8'h40);
    rd(10'h209, 8'h80);
    wr(10'h210, 8'hFF);
    rd(10'h210, 8'h03);
    wr(10'h211, 8'h00);
    rd(10'h211, 8'hFC);
    wr(10'h211, 8'hFF);
    wr(10'h210, 8'h01);
    msn(1'b1);
    wr(10'h210, 8'h02);
    rd(10'h210, 8'h01);
    wr(10'h211, 8'h00);
    rd(10'h211, 8'hFF);
    msn(1'b0);
    $display("test registers done");
    acq(16'hA53C, 5'h10, 1'b0);
    rd(10'h20E, 8'h3C);
    rd(10'h20F, 8'hA5);
    check(16'(logq.size()), 16'd0);
    acq(16'hFFFF, 5'h0C, 1'b0);
    rd(10'h20E, 8'hF0);
    rd(10'h20F, 8'hFF);
    $display("test forced acquisition done");
    wr(10'h213, 8'h0A);
    msn(1'b1);
    acq(16'h4012, 5'h10, 1'b1);
    check(16'(logq.size()), 16'd2);
    check({8'h00, logq[0]}, 16'h0040);
    check({8'h00, logq[1]}, 16'h0012);
    check({12'h000, alarm_flags}, 16'h0008);
    rd(10'h214, 8'h08);
    acq(16'h20FF, 5'h10, 1'b1);
    check({12'h000, alarm_flags}, 16'h0008);
    clr();
    msn(1'b0);
    wr(10'h213, 8'h02);
    wr(10'h211, 8'hFE);
    msn(1'b1);
    acq(16'h10FF, 5'h10, 1'b1);
    check(16'(logq.size()), 16'd1);
    check({8'h00, logq[0]}, 16'h0010);
    check({12'h000, alarm_flags}, 16'h0000);
    msn(1'b0);
    wr(10'h211, 8'hFD);
    msn(1'b1);
    acq(16'h10FF, 5'h10, 1'b1);
    check({12'h000, alarm_flags}, 16'h0004);
    clr();
    $display("test mission logging done");
    tmp(8'h90, 4'h0);
    tmp(8'h30, 4'h1);
    rd(10'h214, 8'h01);
    clr();
    msn(1'b0);
    wr(10'h210, 8'h02);
    msn(1'b1);
    tmp(8'h80, 4'h2);
    tmp(8'h20, 4'h2);
    clr();
    $display("test temperature alarms done");
    msn(1'b0);
    wr(10'h213, 8'h00);
    msn(1'b1);
    @(posedge core_clk);
    sample_tick <= 1'b1;
    @(posedge core_clk);
    sample_tick <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1 check({15'h0000, pump_enable_n}, 16'h0001);
    $display("test logging disabled done");
    wrap_up();
  end
endmodule // serial_input_alarm_logic_tb
